// *** core/psj_regs.vh ***
// Register offsets, fields, reset values and timing for preset/jog selector
`ifndef PSJ_REGS_VH
`define PSJ_REGS_VH
// Word byte addresses (32-bit Avalon-MM, aligned words)
`define PSJ_ADDR_CTRL 8'h00
`define PSJ_ADDR_TERM 8'h04
`define PSJ_ADDR_JOGF 8'h08
`define PSJ_ADDR_JOGT 8'h0C
`define PSJ_ADDR_STAT 8'h10
`define PSJ_ADDR_FOUT 8'h14
`define PSJ_ADDR_PRE0 8'h40
`define PSJ_ADDR_PREND 8'h7C
// Control fields
`define PSJ_CTRL_MODE_LSB 0
`define PSJ_CTRL_REMOTE_LSB 4
`define PSJ_CTRL_SPAT_LSB 8
// Values, in 0.01 Hz units; ramp in 0.1 s units
`define PSJ_SENTINEL 16'h270F
`define PSJ_FMAX 16'h9C40
`define PSJ_PRE1_RST 16'h1388
`define PSJ_PRE2_RST 16'h0BB8
`define PSJ_PRE3_RST 16'h03E8
`define PSJ_JOGF_RST 16'h01F4
`define PSJ_JOGT_RST 16'h0005
`define PSJ_JOGT_MAX 16'h8CA0
`define PSJ_MODE_EXT 4'h3
`define PSJ_MODE_COMB 4'h4
`define PSJ_FC_LOW 4'h0
`define PSJ_FC_MID 4'h1
`define PSJ_FC_HIGH 4'h2
`define PSJ_FC_SECOND 4'h3
`define PSJ_FC_JOG 4'h5
`define PSJ_FC_EXT 4'h8
// Terminal map reset: t0=low, t1=mid, t2=high, t3=second, t4=jog
`define PSJ_TERM_RST 20'h5_3210
`define PSJ_SRC_JOG 3'h1
`define PSJ_SRC_PRESET 3'h2
`define PSJ_SRC_CUR 3'h3
`define PSJ_SRC_VOLT 3'h4
`define PSJ_SRC_NONE 3'h0
`endif

// *** core/psj_selector.v ***
// Preset speed and jog frequency-command selector with Avalon-MM registers
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`include "psj_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module psj_selector #(
  parameter NTERM = 5
) (
  input wire ref_clk,
  input wire reset,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [NTERM-1:0] term_in,
  input wire fwd_start,
  input wire rev_start,
  input wire pu_jog_mode,
  input wire pu_start_btn,
  input wire pu_stop_btn,
  input wire [15:0] freq_cur_in,
  input wire cur_valid,
  input wire [15:0] freq_volt_in,
  input wire volt_valid,
  output reg [15:0] freq_cmd,
  output reg [2:0] freq_src,
  output reg run_cmd,
  output reg run_rev,
  output reg [15:0] ramp_time,
  output reg ramp_to_base,
  output reg alt_ramp_en,
  output reg second_func_active
);
  // =====================================================
  // Input synchronisers
  // =====================================================
  // Contacts and panel keys share one synchroniser bank
  localparam NSYNC = NTERM + 5;
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] sync1_r;
  reg [NSYNC-1:0] sync2_r;
  assign raw_in = {pu_stop_btn, pu_start_btn, pu_jog_mode, rev_start,
                   fwd_start, term_in};
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync1_r <= {NSYNC{1'b0}};
      sync2_r <= {NSYNC{1'b0}};
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end
  wire [NTERM-1:0] term_s = sync2_r[NTERM-1:0];
  wire fwd_s = sync2_r[NTERM];
  wire rev_s = sync2_r[NTERM+1];
  wire pjog_s = sync2_r[NTERM+2];
  wire pstart_s = sync2_r[NTERM+3];
  wire pstop_s = sync2_r[NTERM+4];

  // =====================================================
  // Registers
  // =====================================================
  reg [3:0] mode_r;
  reg [3:0] remote_r;
  reg spat_r;
  reg [4*NTERM-1:0] term_fc_r;
  reg [15:0] jogf_r;
  reg [15:0] jogt_r;
  // Presets one to fifteen sit at consecutive words
  reg [15:0] preset_r [0:14];

  // Single-cycle answer: no wait states needed
  assign avs_waitrequest = 1'b0;
  // Both low byte lanes needed; half a frequency is refused
  wire wr = avs_write & (avs_byteenable[1:0] == 2'b11);
  wire [7:0] pre_off = avs_address - `PSJ_ADDR_PRE0;
  wire pre_hit = (avs_address >= `PSJ_ADDR_PRE0) &&
                 (avs_address < `PSJ_ADDR_PREND) &&
                 (avs_address[1:0] == 2'b00);
  wire [3:0] pre_idx = pre_off[5:2];
  wire [15:0] wdat = avs_writedata[15:0];
  // Out-of-range frequencies are dropped, sentinel allowed from preset four up
  // Limitation: sentinel is raw 9999, so 99.99 Hz is not storable
  wire pre_ok = (wdat <= `PSJ_FMAX) || (wdat == `PSJ_SENTINEL);

  genvar g;
  generate
    for (g = 0; g < 15; g = g + 1) begin : g_pre
      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          if (g == 0)
            preset_r[g] <= `PSJ_PRE1_RST;
          else if (g == 1)
            preset_r[g] <= `PSJ_PRE2_RST;
          else if (g == 2)
            preset_r[g] <= `PSJ_PRE3_RST;
          else
            preset_r[g] <= `PSJ_SENTINEL;
        end else if (wr && pre_hit && pre_idx == g && pre_ok &&
                     !(g < 3 && wdat == `PSJ_SENTINEL)) begin
          // No run or protection gating on preset writes
          preset_r[g] <= wdat;
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_r <= 4'h0;
      remote_r <= 4'h0;
      spat_r <= 1'b0;
      term_fc_r <= `PSJ_TERM_RST;
      jogf_r <= `PSJ_JOGF_RST;
      jogt_r <= `PSJ_JOGT_RST;
    end else if (avs_write) begin
      case (avs_address)
        `PSJ_ADDR_CTRL: begin
          if (avs_byteenable[0])
            mode_r <= avs_writedata[`PSJ_CTRL_MODE_LSB +: 4];
          if (avs_byteenable[0])
            remote_r <= avs_writedata[`PSJ_CTRL_REMOTE_LSB +: 4];
          if (avs_byteenable[1])
            spat_r <= avs_writedata[`PSJ_CTRL_SPAT_LSB];
        end
        `PSJ_ADDR_TERM: begin
          if (avs_byteenable == 4'hF)
            term_fc_r <= avs_writedata[4*NTERM-1:0];
        end
        `PSJ_ADDR_JOGF: begin
          if (wr && wdat <= `PSJ_FMAX)
            jogf_r <= wdat;
        end
        `PSJ_ADDR_JOGT: begin
          if (wr && wdat <= `PSJ_JOGT_MAX)
            jogt_r <= wdat;
        end
        default: begin
        end
      endcase
    end
  end

  // =====================================================
  // Terminal function routing
  // =====================================================
  // One decoder per terminal; a code on two terminals ORs them
  wire [NTERM-1:0] hit_low;
  wire [NTERM-1:0] hit_mid;
  wire [NTERM-1:0] hit_high;
  wire [NTERM-1:0] hit_second;
  wire [NTERM-1:0] hit_jog;
  wire [NTERM-1:0] hit_ext;

  genvar t;
  generate
    for (t = 0; t < NTERM; t = t + 1) begin : g_term
      wire [3:0] fc = term_fc_r[4*t +: 4];
      assign hit_low[t] = term_s[t] & (fc == `PSJ_FC_LOW);
      assign hit_mid[t] = term_s[t] & (fc == `PSJ_FC_MID);
      assign hit_high[t] = term_s[t] & (fc == `PSJ_FC_HIGH);
      assign hit_second[t] = term_s[t] & (fc == `PSJ_FC_SECOND);
      assign hit_jog[t] = term_s[t] & (fc == `PSJ_FC_JOG);
      // Extension only where a terminal carries code 8
      assign hit_ext[t] = term_s[t] & (fc == `PSJ_FC_EXT);
    end
  endgenerate

  wire sel_low = |hit_low;
  wire sel_mid = |hit_mid;
  wire sel_high = |hit_high;
  wire sel_second = |hit_second;
  wire sel_jog = |hit_jog;
  wire sel_ext = |hit_ext;
  wire speed_low = sel_low;
  wire speed_mid = sel_mid;
  wire speed_high = sel_high;

  // =====================================================
  // Preset selection
  // =====================================================
  wire mode_ext = (mode_r == `PSJ_MODE_EXT) || (mode_r == `PSJ_MODE_COMB);
  wire preset_en = mode_ext && (remote_r == 4'h0);
  reg [3:0] pidx;
  reg pidx_valid;
  wire [3:0] combo = {sel_ext, speed_low, speed_mid, speed_high};
  always @* begin
    pidx = 4'h0;
    pidx_valid = 1'b1;
    // Single selects; several of the three: lower select wins
    case (combo)
      4'b0001: pidx = 4'd0;
      4'b0010: pidx = 4'd1;
      4'b0011: pidx = 4'd1;
      4'b0100: pidx = 4'd2;
      4'b0101: pidx = 4'd2;
      4'b0110: pidx = 4'd2;
      4'b0111: pidx = 4'd2;
      4'b0000: pidx_valid = 1'b0;
      // With extension: speeds 8..15 by binary of low,mid,high
      4'b1000: pidx = 4'd7;
      4'b1001: pidx = 4'd8;
      4'b1010: pidx = 4'd9;
      4'b1011: pidx = 4'd10;
      4'b1100: pidx = 4'd11;
      4'b1101: pidx = 4'd12;
      4'b1110: pidx = 4'd13;
      4'b1111: pidx = 4'd14;
      default: pidx_valid = 1'b0;
    endcase
  end

  wire [15:0] pval = preset_r[pidx];
  wire [15:0] pval_rd = preset_r[pre_idx];

  // Ext alone with speed 8 unset falls back to low preset
  wire use_low = (combo == 4'b1000) && (pval == `PSJ_SENTINEL);
  wire [15:0] pfreq = use_low ? preset_r[2] : pval;
  wire preset_hit = preset_en && pidx_valid &&
                    (pfreq != `PSJ_SENTINEL);

  // =====================================================
  // Jog control
  // =====================================================
  wire jog_allowed = (mode_r != `PSJ_MODE_EXT);
  wire mode_comb = (mode_r == `PSJ_MODE_COMB);
  wire pu_jog = jog_allowed && pjog_s;

  // Panel jog latch for mode 4, one-hot
  localparam PJ_IDLE = 2'b01;
  localparam PJ_RUN = 2'b10;
  reg [1:0] pj_state_r;
  reg [1:0] pj_state_nxt;

  always @* begin
    pj_state_nxt = pj_state_r;
    case (pj_state_r)
      PJ_IDLE: begin
        if (mode_comb && pu_jog && pstart_s && !pstop_s)
          pj_state_nxt = PJ_RUN;
      end
      PJ_RUN: begin
        // Stop key, or leaving mode 4, drops the latch
        if (!mode_comb || pstop_s)
          pj_state_nxt = PJ_IDLE;
      end
      default: pj_state_nxt = PJ_IDLE;
    endcase
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pj_state_r <= PJ_IDLE;
    end else begin
      pj_state_r <= pj_state_nxt;
    end
  end

  wire pu_run = (pj_state_r == PJ_RUN);
  wire ext_jog = jog_allowed && sel_jog && (fwd_s | rev_s);
  // Outside mode 4 the keypad jog lasts only while start is held
  wire pu_jog_run = pu_jog && (mode_comb ? pu_run : pstart_s);
  wire jog_on = ext_jog | pu_jog_run;

  // =====================================================
  // Source priority and outputs
  // =====================================================
  reg [15:0] f_nxt;
  reg [2:0] src_nxt;
  always @* begin
    if (jog_on) begin
      f_nxt = jogf_r;
      src_nxt = `PSJ_SRC_JOG;
    end else if (preset_hit) begin
      f_nxt = pfreq;
      src_nxt = `PSJ_SRC_PRESET;
    end else if (cur_valid) begin
      // Lower source passes unmodified
      f_nxt = freq_cur_in;
      src_nxt = `PSJ_SRC_CUR;
    end else if (volt_valid) begin
      f_nxt = freq_volt_in;
      src_nxt = `PSJ_SRC_VOLT;
    end else begin
      f_nxt = 16'h0000;
      src_nxt = `PSJ_SRC_NONE;
    end
  end

  // Jog overrides the ramp; run covers jog and plain start
  wire run_nxt = jog_on | fwd_s | rev_s;
  wire rev_nxt = rev_s & ~fwd_s;
  wire [15:0] ramp_nxt = jog_on ? jogt_r : 16'h0000;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      freq_cmd <= 16'h0000;
      freq_src <= `PSJ_SRC_NONE;
    end else begin
      freq_cmd <= f_nxt;
      freq_src <= src_nxt;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      run_cmd <= 1'b0;
      run_rev <= 1'b0;
      ramp_time <= 16'h0000;
      ramp_to_base <= 1'b0;
      alt_ramp_en <= 1'b0;
      second_func_active <= 1'b0;
    end else begin
      run_cmd <= run_nxt;
      run_rev <= rev_nxt;
      ramp_time <= ramp_nxt;
      ramp_to_base <= jog_on & spat_r;
      alt_ramp_en <= sel_second & ~jog_on;
      second_func_active <= sel_second;
    end
  end

  // =====================================================
  // Read path
  // =====================================================
  always @* begin
    avs_readdata = 32'h0000_0000;
    if (pre_hit) begin
      avs_readdata = {16'h0000, pval_rd};
    end else begin
      case (avs_address)
        `PSJ_ADDR_CTRL:
          avs_readdata = {23'h0, spat_r, remote_r, mode_r};
        `PSJ_ADDR_TERM:
          avs_readdata = {{(32-4*NTERM){1'b0}}, term_fc_r};
        `PSJ_ADDR_JOGF: avs_readdata = {16'h0000, jogf_r};
        `PSJ_ADDR_JOGT: avs_readdata = {16'h0000, jogt_r};
        `PSJ_ADDR_STAT:
          avs_readdata = {21'h0, freq_src, jog_on, preset_hit,
                          sel_second, combo, sel_jog};
        `PSJ_ADDR_FOUT: avs_readdata = {16'h0000, freq_cmd};
        default: avs_readdata = 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** tb/psj_monitor.sv ***
// Port checker for the preset speed and jog selector
`timescale 1ns/1ps
`default_nettype none
module psj_monitor (
  input wire ref_clk,
  input wire reset,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [15:0] freq_cmd,
  input wire [2:0] freq_src,
  input wire run_cmd,
  input wire run_rev,
  input wire [15:0] ramp_time,
  input wire ramp_to_base,
  input wire alt_ramp_en,
  input wire second_func_active
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // ==========================================
  // Bus
  wait_low_a: assert property (!avs_waitrequest)
    else $error("waitrequest seen high");
  unmapped_zero_a: assert property (avs_read && avs_address >= 8'h18
    && avs_address <= 8'h3c |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // ==========================================
  // Selection outputs
  src_range_a: assert property (freq_src <= 3'h4)
    else $error("source code out of range");
  rst_quiet_a: assert property ($fell(reset) |-> freq_src == 3'h0
    && !run_cmd && ramp_time == 16'h0)
    else $error("outputs not quiet after reset");
  rev_run_a: assert property (run_rev |-> run_cmd)
    else $error("reverse without run");
  ramp_idle_a: assert property (freq_src != 3'h1 |->
    ramp_time == 16'h0)
    else $error("ramp time outside jog");
  base_ramp_a: assert property (ramp_to_base |->
    freq_src == 3'h1)
    else $error("base ramp outside jog");
  alt_ramp_a: assert property (alt_ramp_en |->
    second_func_active && freq_src != 3'h1)
    else $error("alternate ramp misused");
  preset_real_a: assert property (freq_src == 3'h2 |->
    freq_cmd != 16'h270f && freq_cmd <= 16'h9c40)
    else $error("preset output invalid");
  cov_jog: cover property (freq_src == 3'h1 && run_cmd);
  cov_preset: cover property (freq_src == 3'h2);
  cov_alt: cover property (alt_ramp_en);
endmodule
`default_nettype wire

// *** tb/psj_contacts.sv ***
// Contact switches and keypad buttons facing the selector
`timescale 1ns/1ps
`default_nettype none
module psj_contacts (
  input wire logic ref_clk,
  input wire logic [9:0] want,
  output logic [4:0] term_in,
  output logic fwd_start,
  output logic rev_start,
  output logic pu_jog_mode,
  output logic pu_start_btn,
  output logic pu_stop_btn
);
  initial {pu_stop_btn, pu_start_btn, pu_jog_mode, rev_start, fwd_start,
    term_in} = 10'h000;
  // Contacts follow one clock late; bounce is not modelled
  always @(posedge ref_clk) begin
    {pu_stop_btn, pu_start_btn, pu_jog_mode, rev_start, fwd_start,
      term_in} <= want;
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the preset speed and jog selector
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  logic [9:0] sw = 10'h000;
  logic cur_valid = 1'b0;
  logic volt_valid = 1'b0;
  wire [4:0] term_in;
  wire fwd_start, rev_start, pu_jog_mode, pu_start_btn, pu_stop_btn;
  wire [15:0] freq_cmd, ramp_time;
  wire [2:0] freq_src;
  wire run_cmd, run_rev, ramp_to_base, alt_ramp_en, second_func_active;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  psj_contacts sws (.ref_clk(ref_clk), .want(sw), .term_in(term_in),
    .fwd_start(fwd_start), .rev_start(rev_start), .pu_jog_mode(pu_jog_mode),
    .pu_start_btn(pu_start_btn), .pu_stop_btn(pu_stop_btn));
  psj_selector #(.NTERM(5)) DUT (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .term_in(term_in), .fwd_start(fwd_start), .rev_start(rev_start),
    .pu_jog_mode(pu_jog_mode), .pu_start_btn(pu_start_btn),
    .pu_stop_btn(pu_stop_btn), .freq_cur_in(16'h0100), .cur_valid(cur_valid),
    .freq_volt_in(16'h0200), .volt_valid(volt_valid), .freq_cmd(freq_cmd),
    .freq_src(freq_src), .run_cmd(run_cmd), .run_rev(run_rev),
    .ramp_time(ramp_time), .ramp_to_base(ramp_to_base),
    .alt_ramp_en(alt_ramp_en), .second_func_active(second_func_active));
  // ==========================================
  // Shared tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // Two sync stages, one register and the contact delay: six is ample
  task set(input logic [9:0] s);
    @(posedge ref_clk);
    sw <= s;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task sel(input logic [9:0] s, input logic [2:0] src, input logic [15:0] f);
    set(s);
    chk(freq_src, src);
    chk(freq_cmd, f);
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    logic [31:0] e;
    for (int n = 0; n < 15; n++) begin
      e = (n > 2) ? 32'h270f : (n == 2) ? 32'h03e8 : 32'h0bb8;
      if (n == 0) e = 32'h1388;
      rd(8'h40 + 8'(4 * n), e);
    end
    rd(8'h08, 32'h01f4);
    rd(8'h0c, 32'h0005);
    rd(8'h04, 32'h0005_3210);
    rd(8'h20, 32'h0);
  endtask
  task t_presets;
    wr(8'h00, 32'h3);
    sel(10'h024, 3'h2, 16'h1388);
    sel(10'h022, 3'h2, 16'h0bb8);
    sel(10'h021, 3'h2, 16'h03e8);
    sel(10'h026, 3'h2, 16'h0bb8);
    sel(10'h027, 3'h2, 16'h03e8);
    wr(8'h40, 32'h07d0);
    sel(10'h024, 3'h2, 16'h07d0);
  endtask
  task t_ext;
    wr(8'h04, 32'h0008_3210);
    sel(10'h030, 3'h2, 16'h03e8);
    wr(8'h5c, 32'h1234);
    sel(10'h030, 3'h2, 16'h1234);
    wr(8'h60, 32'h9c40);
    wr(8'h60, 32'h9c41);
    rd(8'h60, 32'h9c40);
    sel(10'h034, 3'h2, 16'h9c40);
    wr(8'h04, 32'h0005_3210);
  endtask
  task t_src;
    wr(8'h00, 32'h0);
    cur_valid <= 1'b1;
    volt_valid <= 1'b1;
    sel(10'h024, 3'h3, 16'h0100);
    wr(8'h00, 32'h13);
    sel(10'h024, 3'h3, 16'h0100);
    wr(8'h00, 32'h3);
    cur_valid <= 1'b0;
    sel(10'h020, 3'h4, 16'h0200);
    @(posedge ref_clk);
    volt_valid <= 1'b0;
    set(10'h020);
    chk(freq_src, 3'h0);
  endtask
  task t_jog;
    wr(8'h00, 32'h4);
    wr(8'h08, 32'h0400);
    wr(8'h0c, 32'h8ca1);
    rd(8'h0c, 32'h0005);
    sel(10'h034, 3'h1, 16'h0400);
    chk(ramp_time, 16'h0005);
    chk(run_cmd, 1'b1);
    set(10'h03c);
    chk(alt_ramp_en, 1'b0);
    chk(second_func_active, 1'b1);
    set(10'h02c);
    chk(alt_ramp_en, 1'b1);
    wr(8'h00, 32'h104);
    set(10'h054);
    chk(ramp_to_base, 1'b1);
    chk(run_rev, 1'b1);
    wr(8'h00, 32'h3);
    sel(10'h034, 3'h2, 16'h07d0);
  endtask
  task t_keypad;
    wr(8'h00, 32'h0);
    set(10'h180);
    chk(run_cmd, 1'b1);
    set(10'h080);
    chk(run_cmd, 1'b0);
    wr(8'h00, 32'h4);
    set(10'h180);
    set(10'h080);
    chk(run_cmd, 1'b1);
    set(10'h280);
    chk(run_cmd, 1'b0);
  endtask
  task final_report;
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================
  // Clock, timeout and main sequence
  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_presets();
    t_ext();
    t_src();
    t_jog();
    t_keypad();
    final_report();
  end
endmodule
bind psj_selector psj_monitor mon (.ref_clk(ref_clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .freq_cmd(freq_cmd), .freq_src(freq_src), .run_cmd(run_cmd),
  .run_rev(run_rev), .ramp_time(ramp_time), .ramp_to_base(ramp_to_base),
  .alt_ramp_en(alt_ramp_en), .second_func_active(second_func_active));
`default_nettype wire
